// ### rtra_core.sv
// register transfer, ram pointer and ram exchange execution unit
// ----------------------------------------------------------------
// How it works
// - second register copied into accumulator
// - accumulator copied into second register
// - column pointer copied into accumulator
// - accumulator copied into column pointer
// - accumulator and second loaded into extension
// - extension loaded into accumulator and second
// - second is high nibble, accumulator low
// - accumulator copied into direction register
// - pointer load writes row and column together
// - back-to-back pointer loads after first ignored
// - column increment, skip when result zero
// - column decrement, skip when result fifteen
// - memory read loads accumulator, row xor immediate
// - memory exchange swaps, row xor, no skip
// - exchange, row xor, decrement with skip
// - exchange, row xor, increment with skip
// ----------------------------------------------------------------
`timescale 1ns/1ps
module rtra_core (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // decoded command
  input  wire logic                  cmdValid,
  input  wire rtra_pkg::rtra_op_type cmdOp,
  input  wire logic [1:0]            cmdRowImm,
  input  wire logic [3:0]            cmdColImm,
  input  wire logic [1:0]            cmdXorImm,
  output logic                       cmdReady,
  // completion
  output logic                       done,
  output logic                       skipNext,
  // register view
  output logic [3:0]                 acc,
  output logic [3:0]                 second,
  output logic [3:0]                 column,
  output logic [1:0]                 row,
  output logic [7:0]                 extension,
  output logic [2:0]                 direction
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    rtra_pkg::rtra_state_type state;
    logic                     ready;
    rtra_pkg::rtra_op_type    op;
    logic [1:0]               xorImm;
    logic [3:0]               acc;
    logic [3:0]               second;
    logic [3:0]               column;
    logic [1:0]               row;
    logic [7:0]               ext;
    logic [2:0]               dir;
    logic                     loadPrev;
    logic                     done;
    logic                     skip;
  } rtra_core_state_type;

  rtra_core_state_type q;
  rtra_core_state_type d;

  logic                  accepted;
  rtra_pkg::rtra_op_type stepOp;
  logic                  stepDown;
  logic [3:0]            stepCol;
  logic                  stepHit;
  logic                  ramWrEn;
  logic [5:0]            ramAddr;
  logic [3:0]            ramRdData;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // command taken only while idle and enabled
  assign accepted = ce && cmdValid && q.ready;

  // step direction comes from the op being finished
  assign stepOp   = (q.state == rtra_pkg::RTRA_ST_MEM) ? q.op : cmdOp;
  assign stepDown = (stepOp == rtra_pkg::RTRA_OP_COLUMN_DEC) ||
                    (stepOp == rtra_pkg::RTRA_OP_EXCHANGE_DEC);

  rtra_col_step uColStep (
    .down    (stepDown),
    .colIn   (q.column),
    .colOut  (stepCol),
    .wrapHit (stepHit)
  );

  // ram addressed by row and column pointers
  assign ramAddr = {q.row, q.column};
  // old accumulator written in the exchange cycle
  assign ramWrEn = (q.state == rtra_pkg::RTRA_ST_MEM) &&
                   (q.op != rtra_pkg::RTRA_OP_MEMORY_READ);

  rtra_nibble_ram uRam (
    .clk    (clk),
    .rst    (rst),
    .ce     (ce),
    .wrEn   (ramWrEn),
    .addr   (ramAddr),
    .wrData (q.acc),
    .rdData (ramRdData)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d      = q;
    d.done = 1'b0;
    d.skip = 1'b0;
    case (q.state)
      rtra_pkg::RTRA_ST_IDLE: begin
        if (cmdValid && q.ready) begin
          d.done     = 1'b1;
          d.loadPrev = (cmdOp == rtra_pkg::RTRA_OP_POINTER_LOAD);
          case (cmdOp)
            rtra_pkg::RTRA_OP_SECOND_TO_ACC: begin
              d.acc = q.second;
            end
            rtra_pkg::RTRA_OP_ACC_TO_SECOND: begin
              d.second = q.acc;
            end
            rtra_pkg::RTRA_OP_COLUMN_TO_ACC: begin
              d.acc = q.column;
            end
            rtra_pkg::RTRA_OP_ACC_TO_COLUMN: begin
              d.column = q.acc;
            end
            rtra_pkg::RTRA_OP_PAIR_TO_EXT: begin
              d.ext = {q.second, q.acc};
            end
            rtra_pkg::RTRA_OP_EXT_TO_PAIR: begin
              d.second = q.ext[rtra_pkg::EXT_SECOND_LSB +: 4];
              d.acc    = q.ext[rtra_pkg::EXT_ACC_LSB +: 4];
            end
            rtra_pkg::RTRA_OP_ACC_TO_DIRECTION: begin
              d.dir = q.acc[2:0];
            end
            // load only if previous was not a load
            rtra_pkg::RTRA_OP_POINTER_LOAD: begin
              if (!q.loadPrev) begin
                d.row    = cmdRowImm;
                d.column = cmdColImm;
              end
            end
            rtra_pkg::RTRA_OP_COLUMN_INC: begin
              d.column = stepCol;
              d.skip   = stepHit;
            end
            rtra_pkg::RTRA_OP_COLUMN_DEC: begin
              d.column = stepCol;
              d.skip   = stepHit;
            end
            // memory ops wait one cycle for read data
            rtra_pkg::RTRA_OP_MEMORY_READ,
            rtra_pkg::RTRA_OP_MEMORY_EXCHANGE,
            rtra_pkg::RTRA_OP_EXCHANGE_DEC,
            rtra_pkg::RTRA_OP_EXCHANGE_INC: begin
              d.done   = 1'b0;
              d.ready  = 1'b0;
              d.state  = rtra_pkg::RTRA_ST_MEM;
              d.op     = cmdOp;
              d.xorImm = cmdXorImm;
            end
            default: begin
              d.done = 1'b1;
            end
          endcase
        end
      end
      rtra_pkg::RTRA_ST_MEM: begin
        // accumulator from ram, row xor immediate
        d.acc   = ramRdData;
        d.row   = q.row ^ q.xorImm;
        d.done  = 1'b1;
        d.ready = 1'b1;
        d.state = rtra_pkg::RTRA_ST_IDLE;
        if (q.op == rtra_pkg::RTRA_OP_EXCHANGE_DEC ||
            q.op == rtra_pkg::RTRA_OP_EXCHANGE_INC) begin
          d.column = stepCol;
          d.skip   = stepHit;
        end
      end
      default: begin
        d.state = rtra_pkg::RTRA_ST_IDLE;
        d.ready = 1'b1;
      end
    endcase
  end

  // register the copy
  always_ff @(posedge clk) begin
    if (rst) begin
      q.state    <= rtra_pkg::RTRA_ST_IDLE;
      q.ready    <= 1'b1;
      q.op       <= rtra_pkg::RTRA_OP_NOP;
      q.xorImm   <= 2'h0;
      q.acc      <= rtra_pkg::ACC_RST;
      q.second   <= rtra_pkg::SECOND_RST;
      q.column   <= rtra_pkg::COL_RST;
      q.row      <= rtra_pkg::ROW_RST;
      q.ext      <= rtra_pkg::EXT_RST;
      q.dir      <= rtra_pkg::DIR_RST;
      q.loadPrev <= 1'b0;
      q.done     <= 1'b0;
      q.skip     <= 1'b0;
    end else if (ce) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cmdReady  = q.ready;
  assign done      = q.done;
  assign skipNext  = q.skip;
  assign acc       = q.acc;
  assign second    = q.second;
  assign column    = q.column;
  assign row       = q.row;
  assign extension = q.ext;
  assign direction = q.dir;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  second_to_acc_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_SECOND_TO_ACC
    |=> acc == $past(second) && second == $past(second))
    else $error("second not copied to accumulator");

  acc_to_second_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_ACC_TO_SECOND
    |=> second == $past(acc) && acc == $past(acc))
    else $error("accumulator not copied to second");

  column_xfer_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_COLUMN_TO_ACC
    |=> acc == $past(column) && column == $past(column))
    else $error("column not copied to accumulator");
  acc_column_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_ACC_TO_COLUMN
    |=> column == $past(acc))
    else $error("accumulator not copied to column");

  ext_pack_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_PAIR_TO_EXT
    |=> extension == {$past(second), $past(acc)})
    else $error("extension packing wrong");
  ext_unpack_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_EXT_TO_PAIR
    |=> second == $past(extension[7:4]) && acc == $past(extension[3:0]))
    else $error("extension unpacking wrong");

  dir_load_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_ACC_TO_DIRECTION
    |=> direction == $past(acc[2:0]))
    else $error("direction not loaded from accumulator");

  ptr_load_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_POINTER_LOAD
    && !q.loadPrev |=> row == $past(cmdRowImm) && column == $past(cmdColImm))
    else $error("pointer load not applied");
  ptr_suppress_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_POINTER_LOAD
    && q.loadPrev |=> $stable(row) && $stable(column))
    else $error("back to back pointer load applied");

  col_inc_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_COLUMN_INC
    |=> column == $past(column) + 4'h1 && skipNext == (column == 4'h0))
    else $error("column increment or skip wrong");
  col_dec_a: assert property (
    accepted && cmdOp == rtra_pkg::RTRA_OP_COLUMN_DEC
    |=> column == $past(column) - 4'h1 && skipNext == (column == 4'hF))
    else $error("column decrement or skip wrong");

  // memory ops finish two enabled cycles later
  mem_row_xor_a: assert property (
    (accepted && (cmdOp == rtra_pkg::RTRA_OP_MEMORY_READ ||
    cmdOp == rtra_pkg::RTRA_OP_MEMORY_EXCHANGE)) ##1 ce
    |=> done && !skipNext && row == ($past(row, 2) ^ $past(cmdXorImm, 2)))
    else $error("memory op row xor or timing wrong");

  xchg_step_a: assert property (
    (accepted && cmdOp == rtra_pkg::RTRA_OP_EXCHANGE_INC) ##1 ce
    |=> column == $past(column, 2) + 4'h1 && skipNext == (column == 4'h0))
    else $error("exchange increment wrong");
  xchg_dec_a: assert property (
    (accepted && cmdOp == rtra_pkg::RTRA_OP_EXCHANGE_DEC) ##1 ce
    |=> column == $past(column, 2) - 4'h1 && skipNext == (column == 4'hF))
    else $error("exchange decrement wrong");

  // main scenarios
  cov_load_pair_c: cover property (accepted && cmdOp == rtra_pkg::RTRA_OP_POINTER_LOAD
    ##2 accepted && cmdOp == rtra_pkg::RTRA_OP_POINTER_LOAD);
  cov_inc_wrap_c: cover property (accepted && cmdOp == rtra_pkg::RTRA_OP_COLUMN_INC
    && column == 4'hF);
  cov_xchg_skip_c: cover property (skipNext && q.op == rtra_pkg::RTRA_OP_EXCHANGE_INC);
  cov_exchange_c: cover property (ramWrEn && ce);

endmodule // rtra_core

// ### rtra_pkg.sv
// constants and types for the register transfer and ram address unit
package rtra_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int ACC_W     = 4;
  localparam int COL_W     = 4;
  localparam int ROW_W     = 2;
  localparam int EXT_W     = 8;
  localparam int DIR_W     = 3;
  localparam int RAM_AW    = ROW_W + COL_W;
  localparam int RAM_DEPTH = 64;

  // ----------------------------------------------------------------
  // field positions in the extension register
  // ----------------------------------------------------------------
  localparam int EXT_SECOND_LSB = 4;
  localparam int EXT_ACC_LSB    = 0;

  // ----------------------------------------------------------------
  // column values that raise a skip
  // ----------------------------------------------------------------
  localparam logic [3:0] COL_WRAP_UP   = 4'h0;
  localparam logic [3:0] COL_WRAP_DOWN = 4'hF;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] ACC_RST    = 4'h0;
  localparam logic [3:0] SECOND_RST = 4'h0;
  localparam logic [3:0] COL_RST    = 4'h0;
  localparam logic [1:0] ROW_RST    = 2'h0;
  localparam logic [7:0] EXT_RST    = 8'h00;
  localparam logic [2:0] DIR_RST    = 3'h0;
  localparam logic [3:0] RAM_RST    = 4'h0;

  // ----------------------------------------------------------------
  // timing in clock cycles
  // ----------------------------------------------------------------
  localparam int REG_OP_CYCLES = 1;
  localparam int MEM_OP_CYCLES = 2;

  // ----------------------------------------------------------------
  // decoded operations
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RTRA_OP_NOP              = 4'h0,
    RTRA_OP_SECOND_TO_ACC    = 4'h1,
    RTRA_OP_ACC_TO_SECOND    = 4'h2,
    RTRA_OP_COLUMN_TO_ACC    = 4'h3,
    RTRA_OP_ACC_TO_COLUMN    = 4'h4,
    RTRA_OP_PAIR_TO_EXT      = 4'h5,
    RTRA_OP_EXT_TO_PAIR      = 4'h6,
    RTRA_OP_ACC_TO_DIRECTION = 4'h7,
    RTRA_OP_POINTER_LOAD     = 4'h8,
    RTRA_OP_COLUMN_INC       = 4'h9,
    RTRA_OP_COLUMN_DEC       = 4'hA,
    RTRA_OP_MEMORY_READ      = 4'hB,
    RTRA_OP_MEMORY_EXCHANGE  = 4'hC,
    RTRA_OP_EXCHANGE_DEC     = 4'hD,
    RTRA_OP_EXCHANGE_INC     = 4'hE
  } rtra_op_type;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RTRA_ST_IDLE = 2'b01,
    RTRA_ST_MEM  = 2'b10
  } rtra_state_type;

endpackage

// ### rtra_col_step.sv
// column pointer step with wrap detection
`timescale 1ns/1ps
module rtra_col_step (
  // step control
  input  wire logic       down,
  input  wire logic [3:0] colIn,
  // result
  output logic      [3:0] colOut,
  output logic            wrapHit
);

  // modulo sixteen step and skip test
  always_comb begin
    colOut  = down ? colIn - 4'h1 : colIn + 4'h1;
    wrapHit = down ? (colOut == rtra_pkg::COL_WRAP_DOWN) : (colOut == rtra_pkg::COL_WRAP_UP);
  end

endmodule // rtra_col_step

// ### rtra_nibble_ram.sv
// nibble data memory with registered read data
`timescale 1ns/1ps
module rtra_nibble_ram (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ce,
  // access
  input  wire logic       wrEn,
  input  wire logic [5:0] addr,
  input  wire logic [3:0] wrData,
  output logic      [3:0] rdData
);

  typedef struct packed {
    logic [rtra_pkg::RAM_DEPTH-1:0][3:0] mem;
    logic [3:0]                          rdData;
  } rtra_ram_state_type;

  rtra_ram_state_type ramQ;
  rtra_ram_state_type ramD;

  // read old contents, then write
  always_comb begin
    ramD        = ramQ;
    ramD.rdData = ramQ.mem[addr];
    if (wrEn) begin
      ramD.mem[addr] = wrData;
    end
  end

  // register the copy
  always_ff @(posedge clk) begin
    if (rst) begin
      ramQ <= '0;
    end else if (ce) begin
      ramQ <= ramD;
    end
  end

  assign rdData = ramQ.rdData;

endmodule // rtra_nibble_ram

// ### rtra_core_tb.sv
// self-checking testbench for the register transfer and ram address unit
`timescale 1ns/1ps
module rtra_core_tb;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                  clk;
  logic                  rst;
  logic                  ce;
  logic                  cmdValid;
  rtra_pkg::rtra_op_type cmdOp;
  logic [1:0]            cmdRowImm;
  logic [3:0]            cmdColImm;
  logic [1:0]            cmdXorImm;
  logic                  cmdReady;
  logic                  done;
  logic                  skipNext;
  logic [3:0]            acc;
  logic [3:0]            second;
  logic [3:0]            column;
  logic [1:0]            row;
  logic [7:0]            extension;
  logic [2:0]            direction;
  logic                  sk;
  int                    n_mismatch;
  int                    compares;
  int                    cycles;

  // ----------------------------------------------------------------
  // clock, timeout and device
  // ----------------------------------------------------------------
  // 200 MHz clock
  always #2.5 clk = ~clk;

  // hang guard, the whole run needs under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      n_mismatch++;
      results();
    end
  end

  rtra_core dut (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .cmdValid  (cmdValid),
    .cmdOp     (cmdOp),
    .cmdRowImm (cmdRowImm),
    .cmdColImm (cmdColImm),
    .cmdXorImm (cmdXorImm),
    .cmdReady  (cmdReady),
    .done      (done),
    .skipNext  (skipNext),
    .acc       (acc),
    .second    (second),
    .column    (column),
    .row       (row),
    .extension (extension),
    .direction (direction)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // compare one value, zero extended to a byte
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // issue one command, wait for done, keep the skip flag in sk
  task automatic op(input rtra_pkg::rtra_op_type o, input logic [1:0] r,
                    input logic [3:0] c, input logic [1:0] x);
    int   n;
    logic mem;
    n   = 0;
    mem = (o == rtra_pkg::RTRA_OP_MEMORY_READ) || (o == rtra_pkg::RTRA_OP_MEMORY_EXCHANGE) ||
          (o == rtra_pkg::RTRA_OP_EXCHANGE_DEC) || (o == rtra_pkg::RTRA_OP_EXCHANGE_INC);
    @(posedge clk);
    cmdValid  <= 1'b1;
    cmdOp     <= o;
    cmdRowImm <= r;
    cmdColImm <= c;
    cmdXorImm <= x;
    @(posedge clk);
    cmdValid <= 1'b0;
    #1;
    // memory ops refuse new commands for one cycle
    chk({7'h00, cmdReady}, {7'h00, ~mem});
    while (done !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, done}, 8'h01);
    // memory ops answer one cycle later than register ops
    chk(n[7:0], {7'h00, mem});
    sk = skipNext;
  endtask

  // put a value into acc by way of the column pointer
  task automatic setAcc(input logic [1:0] r, input logic [3:0] v);
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, r, v, 2'h0);
    op(rtra_pkg::RTRA_OP_COLUMN_TO_ACC, 2'h0, 4'h0, 2'h0);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // to register moves between acc, second, column, extension, direction
  task automatic testTransfers();
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h1, 4'hA, 2'h0);
    chk({6'h00, row}, 8'h01);
    chk({4'h0, column}, 8'h0A);
    op(rtra_pkg::RTRA_OP_COLUMN_TO_ACC, 2'h0, 4'h0, 2'h0);
    chk({column, acc}, 8'hAA);
    op(rtra_pkg::RTRA_OP_ACC_TO_SECOND, 2'h0, 4'h0, 2'h0);
    chk({second, acc}, 8'hAA);
    setAcc(2'h1, 4'h5);
    op(rtra_pkg::RTRA_OP_PAIR_TO_EXT, 2'h0, 4'h0, 2'h0);
    chk(extension, 8'hA5);
    setAcc(2'h1, 4'h3);
    op(rtra_pkg::RTRA_OP_SECOND_TO_ACC, 2'h0, 4'h0, 2'h0);
    chk({second, acc}, 8'hAA);
    op(rtra_pkg::RTRA_OP_EXT_TO_PAIR, 2'h0, 4'h0, 2'h0);
    chk({second, acc}, 8'hA5);
    setAcc(2'h1, 4'hD);
    op(rtra_pkg::RTRA_OP_ACC_TO_DIRECTION, 2'h0, 4'h0, 2'h0);
    chk({5'h00, direction}, 8'h05);
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h1, 4'h0, 2'h0);
    op(rtra_pkg::RTRA_OP_ACC_TO_COLUMN, 2'h0, 4'h0, 2'h0);
    chk({column, acc}, 8'hDD);
  endtask

  // pointer loads in a row: only the first one acts
  task automatic testLoadRun();
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h2, 4'h7, 2'h0);
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h3, 4'h1, 2'h0);
    chk({2'h0, row, column}, 8'h27);
    chk({7'h00, sk}, 8'h00);
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h0, 4'h9, 2'h0);
    chk({2'h0, row, column}, 8'h27);
  endtask

  // column stepping across both wrap points
  task automatic testColumnStep();
    // a plain command first, else the next pointer load is suppressed
    op(rtra_pkg::RTRA_OP_NOP, 2'h0, 4'h0, 2'h0);
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h0, 4'hF, 2'h0);
    chk({2'h0, row, column}, 8'h0F);
    op(rtra_pkg::RTRA_OP_COLUMN_INC, 2'h0, 4'h0, 2'h0);
    chk({3'h0, sk, column}, 8'h10);
    op(rtra_pkg::RTRA_OP_COLUMN_INC, 2'h0, 4'h0, 2'h0);
    chk({3'h0, sk, column}, 8'h01);
    op(rtra_pkg::RTRA_OP_COLUMN_DEC, 2'h0, 4'h0, 2'h0);
    chk({3'h0, sk, column}, 8'h00);
    op(rtra_pkg::RTRA_OP_COLUMN_DEC, 2'h0, 4'h0, 2'h0);
    chk({3'h0, sk, column}, 8'h1F);
  endtask

  // to ram read and the three exchanges with row xor and column step
  task automatic testMemory();
    setAcc(2'h1, 4'h4);
    op(rtra_pkg::RTRA_OP_MEMORY_EXCHANGE, 2'h0, 4'h0, 2'h2);
    chk({3'h0, sk, acc}, 8'h00);
    chk({2'h0, row, column}, 8'h34);
    // back to row one to read what the exchange left there
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h1, 4'h4, 2'h0);
    op(rtra_pkg::RTRA_OP_MEMORY_READ, 2'h0, 4'h0, 2'h2);
    chk({2'h0, row, column}, 8'h34);
    chk({4'h0, acc}, 8'h04);
    setAcc(2'h1, 4'h9);
    op(rtra_pkg::RTRA_OP_POINTER_LOAD, 2'h1, 4'h0, 2'h0);
    op(rtra_pkg::RTRA_OP_EXCHANGE_DEC, 2'h0, 4'h0, 2'h1);
    chk({3'h0, sk, acc}, 8'h10);
    chk({2'h0, row, column}, 8'h0F);
    op(rtra_pkg::RTRA_OP_EXCHANGE_INC, 2'h0, 4'h0, 2'h1);
    chk({3'h0, sk, acc}, 8'h10);
    chk({2'h0, row, column}, 8'h10);
    op(rtra_pkg::RTRA_OP_MEMORY_EXCHANGE, 2'h0, 4'h0, 2'h0);
    chk({4'h0, acc}, 8'h09);
  endtask

  // clock enable low freezes state and holds done
  task automatic testHold();
    @(posedge clk);
    ce       <= 1'b0;
    cmdValid <= 1'b1;
    cmdOp    <= rtra_pkg::RTRA_OP_COLUMN_INC;
    repeat (3) @(posedge clk);
    ce <= 1'b1;
    #1;
    chk({3'h0, done, column}, 8'h00);
    @(posedge clk);
    ce       <= 1'b0;
    cmdValid <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({3'h0, done, column}, 8'h11);
    @(posedge clk);
    ce <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  // print the counts and the verdict, then stop
  task automatic results();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    clk        = 1'b0;
    rst        = 1'b1;
    ce         = 1'b1;
    cmdValid   = 1'b0;
    cmdOp      = rtra_pkg::RTRA_OP_NOP;
    cmdRowImm  = 2'h0;
    cmdColImm  = 4'h0;
    cmdXorImm  = 2'h0;
    sk         = 1'b0;
    n_mismatch = 0;
    compares   = 0;
    cycles     = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk({cmdReady, done, skipNext, 5'h00}, 8'h80);
    chk({second, acc}, 8'h00);
    chk({column, 1'b0, direction}, 8'h00);
    chk({row, 6'h00}, 8'h00);
    chk(extension, 8'h00);
    testTransfers();
    testLoadRun();
    testColumnStep();
    testMemory();
    testHold();
    results();
  end

endmodule // rtra_core_tb
